/* File: hdl/pmc_pkg.sv */
// power mode controller package: register offsets, field positions, reset values, timing
// assumes a single 200 MHz clock domain
`default_nettype none
package pmc_pkg;
    // ------------------------------------------------------------
    // register map (word-indexed plain port, 8-bit data)
    // ------------------------------------------------------------
    localparam logic [3:0] PMC_ADDR_PWR    = 4'h0; // power_control_register
    localparam logic [3:0] PMC_ADDR_OSC    = 4'h1; // internal_oscillator_control_register
    localparam logic [3:0] PMC_ADDR_CFG    = 4'h2; // wake and monitor enables
    localparam logic [3:0] PMC_ADDR_STAT   = 4'h3; // sticky event status, write one to clear
    localparam logic [3:0] PMC_ADDR_MASK   = 4'h4; // interrupt mask
    localparam logic [3:0] PMC_ADDR_STATE  = 4'h5; // current power state, read only
    localparam logic [3:0] PMC_ADDR_RSTVEC = 4'h6; // restart address low byte, read only

    // field positions
    localparam int PMC_PWR_IDLE_BIT  = 0;
    localparam int PMC_PWR_STOP_BIT  = 1;
    localparam int PMC_OSC_SUSP_BIT  = 5;
    localparam int PMC_CFG_WDT_BIT   = 0; // watchdog_counter enable
    localparam int PMC_CFG_LCM_BIT   = 1; // lost_clock_monitor enable
    localparam int PMC_CFG_CMPW_BIT  = 2; // comparator wake enable

    // status bit positions
    localparam int PMC_EV_IDLE_WAKE  = 0;
    localparam int PMC_EV_SUSP_WAKE  = 1;
    localparam int PMC_EV_WDT_RST    = 2;
    localparam int PMC_EV_LCM_RST    = 3;
    localparam int PMC_EV_NUM        = 4;

    // reset values
    localparam logic [7:0] PMC_PWR_RST   = 8'h00;
    localparam logic [7:0] PMC_OSC_RST   = 8'h00;
    localparam logic [7:0] PMC_CFG_RST   = 8'h03;
    localparam logic [7:0] PMC_MASK_RST  = 8'h00;
    localparam logic [15:0] PMC_RESET_VECTOR = 16'h0000;

    // timing
    localparam int PMC_CLK_MHZ       = 200;
    localparam int PMC_LCM_TIMEOUT_US = 100;
    localparam int PMC_LCM_CYCLES    = PMC_LCM_TIMEOUT_US * PMC_CLK_MHZ;
    localparam int PMC_WDT_CYCLES    = 65536;
    localparam int PMC_RST_PULSE     = 4; // internal reset request length

    // one-hot power states
    typedef enum logic [3:0] {
        PMC_ST_RUN  = 4'h1,
        PMC_ST_IDLE = 4'h2,
        PMC_ST_STOP = 4'h4,
        PMC_ST_SUSP = 4'h8
    } pmc_state_t;
endpackage
`default_nettype wire

/* File: hdl/pmc_wake_if.sv */
// interface carrying wake and timeout requests between the timer and the main controller
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface pmc_wake_if;
    logic        wdt_run;   // watchdog_counter counting
    logic        lcm_run;   // lost_clock_monitor counting
    logic        wdt_kick;  // restart watchdog count
    logic        wdt_fire;  // watchdog expiry pulse
    logic        lcm_fire;  // lost clock timeout pulse
    modport ctl (output wdt_run, output lcm_run, output wdt_kick, input wdt_fire, input lcm_fire);
    modport tmr (input wdt_run, input lcm_run, input wdt_kick, output wdt_fire, output lcm_fire);
endinterface
`default_nettype wire

/* File: hdl/pmc_timers.sv */
// watchdog and lost-clock timeout counters for the power mode controller
// assumes the controller decides when each counter runs
`timescale 1ns/1ps
`default_nettype none
module pmc_timers
    import pmc_pkg::*;
#(
    parameter int WDT_CYCLES = PMC_WDT_CYCLES,
    parameter int LCM_CYCLES = PMC_LCM_CYCLES
) (
    input  wire logic clk,  // system clock
    input  wire logic srst, // synchronous reset
    pmc_wake_if.tmr   wk    // control and expiry pulses
);
    logic [31:0] wdt_cnt_r;
    logic [31:0] lcm_cnt_r;
    logic        wdt_fire_r;
    logic        lcm_fire_r;

    // watchdog keeps counting through idle; one pulse on expiry
    always_ff @(posedge clk) begin
        if (srst || wk.wdt_kick || !wk.wdt_run) begin
            wdt_cnt_r  <= 32'h0;
            wdt_fire_r <= 1'b0;
        end else begin
            wdt_fire_r <= (wdt_cnt_r == 32'(WDT_CYCLES - 1));
            wdt_cnt_r  <= (wdt_cnt_r == 32'(WDT_CYCLES - 1)) ? 32'h0 : wdt_cnt_r + 32'h1;
        end
    end

    // lost clock monitor counts only while the oscillator is halted in stop
    always_ff @(posedge clk) begin
        if (srst || !wk.lcm_run) begin
            lcm_cnt_r  <= 32'h0;
            lcm_fire_r <= 1'b0;
        end else begin
            lcm_fire_r <= (lcm_cnt_r == 32'(LCM_CYCLES - 1));
            lcm_cnt_r  <= (lcm_cnt_r == 32'(LCM_CYCLES - 1)) ? 32'h0 : lcm_cnt_r + 32'h1;
        end
    end

    assign wk.wdt_fire = wdt_fire_r;
    assign wk.lcm_fire = lcm_fire_r;
endmodule // pmc_timers
`default_nettype wire

/* File: hdl/pmc_core.sv */
// power mode controller: idle, stop and suspend sequencing with register port
// assumes cpu reports instruction completion; resets are applied through srst
`timescale 1ns/1ps
`default_nettype none
module pmc_core
    import pmc_pkg::*;
#(
    parameter int WDT_CYCLES = PMC_WDT_CYCLES, // watchdog expiry count
    parameter int LCM_CYCLES = PMC_LCM_CYCLES  // lost clock timeout count
) (
    input  wire logic       clk,          // 200 MHz system clock
    input  wire logic       srst,         // synchronous reset, active high
    input  wire logic [3:0] reg_addr,     // register index
    input  wire logic [7:0] reg_wdata,    // write data
    input  wire logic       reg_wr,       // write strobe
    input  wire logic       reg_rd,       // read strobe
    output logic      [7:0] reg_rdata,    // read data, cycle after strobe
    input  wire logic       instr_done,   // cpu finished current instruction
    input  wire logic       irq_pending,  // an enabled interrupt is asserted
    input  wire logic       port_match,   // port match event
    input  wire logic       cmp_low,      // comparator output low
    input  wire logic       wdt_kick,     // software watchdog refresh
    output logic            cpu_clk_en,   // cpu clock gate enable
    output logic            osc_stop,     // internal oscillator stop
    output logic            periph_clk_en,// digital peripheral clock enable
    output logic            port_match_en,// port match logic enabled
    output logic            int_rst_req,  // internal reset request
    output logic            resume_irq,   // cpu to service interrupt on resume
    output logic            irq           // level interrupt output
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    pmc_state_t  state_r, state_nxt;
    logic [5:0]  gpflag_r;
    logic        idle_req_r;
    logic        stop_req_r;
    logic [7:0]  osc_r;
    logic [7:0]  cfg_r;
    logic [PMC_EV_NUM-1:0] stat_r;
    logic [PMC_EV_NUM-1:0] mask_r;
    logic [PMC_EV_NUM-1:0] ev_set;
    logic [2:0]  rst_cnt_r;
    logic        wake_idle;
    logic        wake_susp;

    pmc_wake_if wk ();

    pmc_timers #(
        .WDT_CYCLES (WDT_CYCLES),
        .LCM_CYCLES (LCM_CYCLES)
    ) u_timers (
        .clk  (clk),
        .srst (srst),
        .wk   (wk)
    );

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // mode select bits are requests: they latch until the instruction completes
    always_ff @(posedge clk) begin
        if (srst) begin
            gpflag_r   <= 6'h00;
            idle_req_r <= 1'b0;
            stop_req_r <= 1'b0;
        end else if (reg_wr && reg_addr == PMC_ADDR_PWR) begin
            gpflag_r   <= reg_wdata[7:2];
            idle_req_r <= reg_wdata[PMC_PWR_IDLE_BIT] | idle_req_r;
            stop_req_r <= reg_wdata[PMC_PWR_STOP_BIT] | stop_req_r;
        end else if (state_r != PMC_ST_RUN) begin
            idle_req_r <= 1'b0;
            stop_req_r <= 1'b0;
        end
    end

    // suspend bit self-clears once the wake is taken
    always_ff @(posedge clk) begin
        if (srst) begin
            osc_r <= PMC_OSC_RST;
        end else if (reg_wr && reg_addr == PMC_ADDR_OSC) begin
            osc_r <= reg_wdata;
        end else if (state_r == PMC_ST_SUSP && wake_susp) begin
            osc_r[PMC_OSC_SUSP_BIT] <= 1'b0;
        end
    end

    // enables and mask take effect on the edge after the write
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_r  <= PMC_CFG_RST;
            mask_r <= PMC_MASK_RST[PMC_EV_NUM-1:0];
        end else if (reg_wr && reg_addr == PMC_ADDR_CFG) begin
            cfg_r <= reg_wdata;
        end else if (reg_wr && reg_addr == PMC_ADDR_MASK) begin
            mask_r <= reg_wdata[PMC_EV_NUM-1:0];
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    assign wake_idle = irq_pending;
    assign wake_susp = port_match || (cmp_low && cfg_r[PMC_CFG_CMPW_BIT]);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PMC_ST_RUN: begin
                if (instr_done && stop_req_r) begin
                    state_nxt = PMC_ST_STOP;
                end else if (instr_done && osc_r[PMC_OSC_SUSP_BIT]) begin
                    state_nxt = PMC_ST_SUSP;
                end else if (instr_done && idle_req_r) begin
                    state_nxt = PMC_ST_IDLE;
                end
            end
            PMC_ST_IDLE: begin
                if (wake_idle) begin
                    state_nxt = PMC_ST_RUN;
                end
            end
            PMC_ST_STOP: begin
                state_nxt = PMC_ST_STOP;
            end
            PMC_ST_SUSP: begin
                if (wake_susp) begin
                    state_nxt = PMC_ST_RUN;
                end
            end
            default: state_nxt = PMC_ST_RUN;
        endcase
    end

    // reset always returns to run; cpu then fetches from the reset vector
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= PMC_ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // timers and internal reset request
    // ------------------------------------------------------------
    // watchdog held cleared in stop and suspend since its clock is gone
    assign wk.wdt_run  = cfg_r[PMC_CFG_WDT_BIT] &&
                         (state_r == PMC_ST_RUN || state_r == PMC_ST_IDLE);
    assign wk.lcm_run  = cfg_r[PMC_CFG_LCM_BIT] && state_r == PMC_ST_STOP;
    assign wk.wdt_kick = wdt_kick;

    // stretch expiry into a multi-cycle reset request for the reset block
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_cnt_r   <= 3'h0;
            int_rst_req <= 1'b0;
        end else if (wk.wdt_fire || wk.lcm_fire) begin
            rst_cnt_r   <= 3'(PMC_RST_PULSE - 1);
            int_rst_req <= 1'b1;
        end else if (rst_cnt_r != 3'h0) begin
            rst_cnt_r   <= rst_cnt_r - 3'h1;
        end else begin
            int_rst_req <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // clock gating outputs
    // ------------------------------------------------------------
    // registered from the next state so gates change with the state register
    always_ff @(posedge clk) begin
        if (srst) begin
            cpu_clk_en    <= 1'b1;
            osc_stop      <= 1'b0;
            periph_clk_en <= 1'b1;
            port_match_en <= 1'b1;
            resume_irq    <= 1'b0;
        end else begin
            cpu_clk_en    <= (state_nxt == PMC_ST_RUN);
            osc_stop      <= (state_nxt == PMC_ST_STOP) || (state_nxt == PMC_ST_SUSP);
            periph_clk_en <= (state_nxt == PMC_ST_RUN) || (state_nxt == PMC_ST_IDLE);
            port_match_en <= (state_nxt != PMC_ST_STOP);
            resume_irq    <= (state_r != PMC_ST_RUN) && (state_nxt == PMC_ST_RUN) &&
                             irq_pending;
        end
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    // one-cycle event strobes feeding the sticky status bits
    assign ev_set[PMC_EV_IDLE_WAKE] = (state_r == PMC_ST_IDLE) && wake_idle;
    assign ev_set[PMC_EV_SUSP_WAKE] = (state_r == PMC_ST_SUSP) && wake_susp;
    assign ev_set[PMC_EV_WDT_RST]   = wk.wdt_fire;
    assign ev_set[PMC_EV_LCM_RST]   = wk.lcm_fire;

    // set beats clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < PMC_EV_NUM; gi++) begin : g_stat
            always_ff @(posedge clk) begin
                if (srst) begin
                    stat_r[gi] <= 1'b0;
                end else if (ev_set[gi]) begin
                    stat_r[gi] <= 1'b1;
                end else if (reg_wr && reg_addr == PMC_ADDR_STAT && reg_wdata[gi]) begin
                    stat_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // new events are ored in so the line rises with the status bit, not a cycle later
    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((stat_r | ev_set) & mask_r);
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // read data stand one cycle only, zero otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                PMC_ADDR_PWR:    reg_rdata <= {gpflag_r, 2'b00};
                PMC_ADDR_OSC:    reg_rdata <= osc_r;
                PMC_ADDR_CFG:    reg_rdata <= cfg_r;
                PMC_ADDR_STAT:   reg_rdata <= {4'h0, stat_r};
                PMC_ADDR_MASK:   reg_rdata <= {4'h0, mask_r};
                PMC_ADDR_STATE:  reg_rdata <= {4'h0, state_r};
                PMC_ADDR_RSTVEC: reg_rdata <= PMC_RESET_VECTOR[7:0];
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_idle_entry: assert property (@(posedge clk) disable iff (srst)
        (state_r == PMC_ST_RUN && instr_done && idle_req_r && !stop_req_r &&
         !osc_r[PMC_OSC_SUSP_BIT]) |=> (state_r == PMC_ST_IDLE) ##0 !cpu_clk_en)
        else $error("idle not entered after instruction");
    a_idle_periph_on: assert property (@(posedge clk) disable iff (srst)
        (state_r == PMC_ST_IDLE) |-> periph_clk_en)
        else $error("peripheral clock gated in idle");
    a_idle_wake: assert property (@(posedge clk) disable iff (srst)
        (state_r == PMC_ST_IDLE && irq_pending) |=> (state_r == PMC_ST_RUN && cpu_clk_en))
        else $error("idle did not wake on interrupt");
    a_stop_hold: assert property (@(posedge clk) disable iff (srst)
        (state_r == PMC_ST_STOP) |=> (state_r == PMC_ST_STOP) ##0 osc_stop)
        else $error("stop left without reset");
    a_stop_wdt_off: assert property (@(posedge clk) disable iff (srst)
        (state_r == PMC_ST_STOP) |-> !wk.wdt_run)
        else $error("watchdog running in stop");
    a_stop_entry: assert property (@(posedge clk) disable iff (srst)
        (state_r == PMC_ST_RUN && instr_done && stop_req_r) |=>
        (state_r == PMC_ST_STOP && osc_stop && !cpu_clk_en && !periph_clk_en))
        else $error("stop not entered after instruction");
    a_susp_gates: assert property (@(posedge clk) disable iff (srst)
        (state_r == PMC_ST_SUSP) |-> (osc_stop && !cpu_clk_en && !periph_clk_en && port_match_en))
        else $error("wrong gates in suspend");
    a_lcm_reset: assert property (@(posedge clk) disable iff (srst)
        wk.lcm_fire |=> int_rst_req [*4])
        else $error("lost clock reset request too short");
    a_susp_wake: assert property (@(posedge clk) disable iff (srst)
        (state_r == PMC_ST_SUSP && port_match) |=> (state_r == PMC_ST_RUN) ##1 stat_r[1])
        else $error("suspend did not wake on port match");
    a_pwr_read_zero: assert property (@(posedge clk) disable iff (srst)
        (reg_rd && reg_addr == PMC_ADDR_PWR) |=> (reg_rdata[1:0] == 2'b00))
        else $error("mode bits read nonzero");
    a_irq_level: assert property (@(posedge clk) disable iff (srst)
        ($past(stat_r) & mask_r) != 4'h0 && $stable(mask_r) |-> irq)
        else $error("interrupt missing for set status");

    // main scenarios: each wake path and each internal reset source
    c_idle_wake: cover property (@(posedge clk) state_r == PMC_ST_IDLE ##1 state_r == PMC_ST_RUN);
    c_susp_wake: cover property (@(posedge clk) state_r == PMC_ST_SUSP ##1 state_r == PMC_ST_RUN);
    c_stop_lcm:  cover property (@(posedge clk) state_r == PMC_ST_STOP && wk.lcm_fire);
    c_wdt_idle:  cover property (@(posedge clk) state_r == PMC_ST_IDLE && wk.wdt_fire);
endmodule // pmc_core
`default_nettype wire

/* File: verif/pmc_cpu_model.sv */
// cpu core stand-in: reports instruction completion while its clock is gated on
// assumes the controller drives cpu_clk_en from registered state on clk
`timescale 1ns/1ps
`default_nettype none
module pmc_cpu_model (
    input  wire logic clk,        // system clock
    input  wire logic srst,       // synchronous reset, active high
    input  wire logic cpu_clk_en, // cpu clock gate from the controller
    input  wire logic go_slow,    // three-cycle instructions instead of one
    output logic      instr_done  // current instruction completes this cycle
);
    // ------------------------------------------------------------
    // instruction timing
    // ------------------------------------------------------------
    logic [1:0] cnt_r;
    logic       was_on_r;

    // a gated cpu makes no progress, so the count restarts on every halt
    always_ff @(posedge clk) begin
        if (srst || !cpu_clk_en) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
        end
    end

    // remembers whether the previous cycle was clocked
    always_ff @(posedge clk) begin
        was_on_r <= srst ? 1'b0 : cpu_clk_en;
    end

    // the cycle after a wake fetches the second opcode byte, so nothing completes there
    assign instr_done = cpu_clk_en && was_on_r && (!go_slow || cnt_r == 2'h2);
endmodule // pmc_cpu_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the power mode controller: register table, idle, stop, suspend
// assumes one 200 MHz clock and the cpu stand-in model at the core side
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmc_pkg::*;
    localparam int WDT_N = 20; // shortened watchdog count
    localparam int LCM_N = 30; // shortened lost clock timeout
    typedef struct { logic wr; logic [3:0] a; logic [7:0] d; logic [7:0] e; } pmc_row_t;
    logic       clk, srst, reg_wr, reg_rd, irq_pending, port_match, cmp_low, wdt_kick, go_slow;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       instr_done, cpu_clk_en, osc_stop, periph_clk_en, port_match_en;
    logic       int_rst_req, resume_irq, irq;
    int         n_mismatch, comparisons, cyc, n;
    pmc_row_t   rows [14];

    pmc_core #(.WDT_CYCLES(WDT_N), .LCM_CYCLES(LCM_N)) i_pmc_core (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_done(instr_done),
        .irq_pending(irq_pending), .port_match(port_match), .cmp_low(cmp_low),
        .wdt_kick(wdt_kick), .cpu_clk_en(cpu_clk_en), .osc_stop(osc_stop),
        .periph_clk_en(periph_clk_en), .port_match_en(port_match_en),
        .int_rst_req(int_rst_req), .resume_irq(resume_irq), .irq(irq));
    pmc_cpu_model i_pmc_cpu_model (.clk(clk), .srst(srst), .cpu_clk_en(cpu_clk_en),
        .go_slow(go_slow), .instr_done(instr_done));

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // the whole run needs well under a thousand cycles; three thousand means a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            $display("[FAIL] run_length expected done seen timeout");
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // compares and bus cycles
    // ------------------------------------------------------------
    task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(string nm, logic e, logic g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    // gates packed as {cpu clock, oscillator stop, peripheral clock, port match}
    task automatic gates(logic [3:0] e);
        chk_byte("gates", {4'h0, e}, {4'h0, cpu_clk_en, osc_stop, periph_clk_en, port_match_en});
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(string nm, logic [3:0] a, logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        chk_byte(nm, e, reg_rdata);
    endtask
    task automatic wait_gate(logic lvl);
        n = 0;
        @(negedge clk);
        while (cpu_clk_en !== lvl && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk_bit("cpu_clk_en", lvl, cpu_clk_en);
    endtask
    task automatic wait_rst(int lim);
        n = 0;
        @(negedge clk);
        while (int_rst_req !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic do_reset();
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {srst, reg_wr, reg_rd, irq_pending, port_match, cmp_low, wdt_kick, go_slow} = 8'h80;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        // watchdog is on out of reset, so the enable is turned off in row 1
        rows = '{'{1'b0, PMC_ADDR_CFG, 8'h00, PMC_CFG_RST}, '{1'b1, PMC_ADDR_CFG, 8'h04, 8'h04},
                 '{1'b0, PMC_ADDR_PWR, 8'h00, PMC_PWR_RST}, '{1'b0, PMC_ADDR_OSC, 8'h00, PMC_OSC_RST},
                 '{1'b0, PMC_ADDR_MASK, 8'h00, PMC_MASK_RST}, '{1'b0, PMC_ADDR_STATE, 8'h00, 8'h01},
                 '{1'b0, PMC_ADDR_STAT, 8'h00, 8'h00}, '{1'b0, PMC_ADDR_RSTVEC, 8'h00, 8'h00},
                 '{1'b1, PMC_ADDR_PWR, 8'hA8, 8'hA8}, '{1'b1, PMC_ADDR_MASK, 8'h0F, 8'h0F},
                 '{1'b1, PMC_ADDR_STATE, 8'hFF, 8'h01}, '{1'b1, PMC_ADDR_RSTVEC, 8'h12, 8'h00},
                 '{1'b1, 4'hF, 8'h55, 8'h00}, '{1'b1, 4'h7, 8'hAA, 8'h00}};
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        gates(4'hB);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            rd("register", rows[i].a, rows[i].e);
        end
        $display("test registers done");
        // idle, woken by an enabled interrupt
        wr(PMC_ADDR_PWR, 8'h01);
        wait_gate(1'b0);
        gates(4'h3);
        rd("power", PMC_ADDR_PWR, 8'h00);
        rd("state", PMC_ADDR_STATE, 8'h02);
        @(posedge clk);
        irq_pending <= 1'b1;
        wait_gate(1'b1);
        chk_bit("resume_irq", 1'b1, resume_irq);
        @(posedge clk);
        irq_pending <= 1'b0;
        @(negedge clk);
        chk_bit("irq", 1'b1, irq);
        rd("status", PMC_ADDR_STAT, 8'h01);
        wr(PMC_ADDR_STAT, 8'h01);
        rd("status", PMC_ADDR_STAT, 8'h00);
        chk_bit("irq", 1'b0, irq);
        $display("test idle done");
        // kicked watchdog holds off, then expires in idle and reset restarts
        wr(PMC_ADDR_CFG, 8'h01);
        repeat (6) begin
            repeat (8) @(posedge clk);
            wdt_kick <= 1'b1;
            @(posedge clk);
            wdt_kick <= 1'b0;
        end
        @(negedge clk);
        chk_bit("int_rst_req", 1'b0, int_rst_req);
        wr(PMC_ADDR_PWR, 8'h01);
        wait_gate(1'b0);
        wait_rst(WDT_N + 10);
        chk_bit("int_rst_req", 1'b1, int_rst_req);
        rd("status", PMC_ADDR_STAT, 8'h04);
        do_reset();
        wr(PMC_ADDR_CFG, 8'h00);
        @(negedge clk);
        gates(4'hB);
        rd("restart", PMC_ADDR_RSTVEC, PMC_RESET_VECTOR[7:0]);
        rd("state", PMC_ADDR_STATE, 8'h01);
        $display("test watchdog done");
        // stop and idle asked together: stop wins; it ignores interrupts and port match
        wr(PMC_ADDR_PWR, 8'h03);
        wait_gate(1'b0);
        gates(4'h4);
        @(posedge clk);
        {irq_pending, port_match} <= 2'h3;
        repeat (LCM_N + 10) @(posedge clk);
        {irq_pending, port_match} <= 2'h0;
        @(negedge clk);
        gates(4'h4);
        chk_bit("resume_irq", 1'b0, resume_irq);
        chk_bit("int_rst_req", 1'b0, int_rst_req);
        rd("state", PMC_ADDR_STATE, 8'h04);
        do_reset();
        wr(PMC_ADDR_CFG, 8'h02);
        wr(PMC_ADDR_PWR, 8'h02);
        wait_gate(1'b0);
        wait_rst(LCM_N + 10);
        chk_bit("int_rst_req", 1'b1, int_rst_req);
        chk_bit("lcm_delay", 1'b1, n >= LCM_N - 2);
        rd("status", PMC_ADDR_STAT, 8'h08);
        do_reset();
        wr(PMC_ADDR_CFG, 8'h04);
        $display("test stop done");
        // suspend: port match wake, comparator wake with interrupt, reset wake
        wr(PMC_ADDR_MASK, 8'h02);
        go_slow <= 1'b1;
        wr(PMC_ADDR_OSC, 8'h20);
        wait_gate(1'b0);
        gates(4'h5);
        rd("state", PMC_ADDR_STATE, 8'h08);
        @(posedge clk);
        port_match <= 1'b1;
        wait_gate(1'b1);
        chk_bit("resume_irq", 1'b0, resume_irq);
        @(posedge clk);
        port_match <= 1'b0;
        rd("osc", PMC_ADDR_OSC, 8'h00);
        rd("status", PMC_ADDR_STAT, 8'h02);
        chk_bit("irq", 1'b1, irq);
        wr(PMC_ADDR_STAT, 8'h02);
        wr(PMC_ADDR_OSC, 8'h20);
        wait_gate(1'b0);
        @(posedge clk);
        {irq_pending, cmp_low} <= 2'h3;
        wait_gate(1'b1);
        chk_bit("resume_irq", 1'b1, resume_irq);
        @(posedge clk);
        {irq_pending, cmp_low} <= 2'h0;
        wr(PMC_ADDR_CFG, 8'h00);
        wr(PMC_ADDR_OSC, 8'h20);
        wait_gate(1'b0);
        @(posedge clk);
        cmp_low <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        gates(4'h5);
        do_reset();
        cmp_low <= 1'b0;
        @(negedge clk);
        gates(4'hB);
        rd("state", PMC_ADDR_STATE, 8'h01);
        $display("test suspend done");
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
